/* File: pkg/input_select_pkg.sv */
// Purpose: Shared constants for the audio input select and fallback block
// Assumes: 10 MHz system clock, Avalon-MM slave with 32-bit data
// Notes:   Byte offsets, field positions, reset values and timing counts
package input_select_pkg;

  // Register byte offsets
  localparam logic [3:0] ctrl_off       = 4'h0;
  localparam logic [3:0] status_off     = 4'h4;
  localparam logic [3:0] irq_status_off = 4'h8;
  localparam logic [3:0] irq_mask_off   = 4'hc;

  // Rate select codes
  typedef enum logic [1:0] {
    rate_32k_choice      = 2'h0,
    rate_48k_choice      = 2'h1,
    digital_input_choice = 2'h2
  } input_rate_select_t;

  // Lock loss policy codes
  localparam logic lock_loss_unlock = 1'b0;
  localparam logic revert_to_analog = 1'b1;

  // Control fields
  localparam int ctrl_rate_lsb   = 0;
  localparam int ctrl_policy_bit = 2;
  localparam int ctrl_inline_bit = 3;
  localparam int ctrl_atten_lsb  = 8;
  localparam int atten_w         = 6;

  // Reset values
  localparam logic [1:0] rate_sel_rst  = 2'h1;
  localparam logic       policy_rst    = 1'b1;
  localparam logic       inline_rst    = 1'b0;
  localparam logic [5:0] atten_rst     = 6'h00;

  // Status fields
  localparam int st_lock_bit    = 0;
  localparam int st_oolock_bit  = 1;
  localparam int st_digital_bit = 2;
  localparam int st_rate48_bit  = 3;
  localparam int st_mute_bit    = 4;
  localparam int st_flash_bit   = 5;
  localparam int st_seen_bit    = 6;

  // Interrupt events: lock lost, lock gained
  localparam int irq_w        = 2;
  localparam int irq_lost_bit = 0;
  localparam int irq_gain_bit = 1;

  // Rates in samples per second
  localparam int fs_32k_hz  = 32000;
  localparam int fs_48k_hz  = 48000;
  localparam int fs_mid_hz  = (fs_32k_hz + fs_48k_hz) / 2;
  localparam int clk_hz     = 10_000_000;

  // Link loss timeout: no link edge for this long means no signal
  localparam int lock_timeout_us = 100;
  localparam int lock_timeout_cyc = lock_timeout_us * (clk_hz / 1_000_000);
  // Frame period limit: a 40 kHz frame lasts 25 us; shorter frames are 48k
  localparam int mid_period_cyc = clk_hz / fs_mid_hz;
  localparam int frame_edges    = 64;

  // Display flash half period
  localparam int flash_ms  = 250;
  localparam int flash_cyc = flash_ms * (clk_hz / 1000);

  // Fixed rate strobe divisors, rounded down
  localparam int div_32k_cyc = clk_hz / fs_32k_hz;
  localparam int div_48k_cyc = clk_hz / fs_48k_hz;

  localparam int cnt_w   = 22;
  localparam int audio_w = 24;

endpackage

/* File: rtl/link_monitor.sv */
// Purpose: Watches the digital link clock, reports lock and frame rate
// Assumes: link_clk is already synchronised to clk
// Notes:   One frame strobe per frame_edges link clock rising edges
`timescale 1ns/1ps
module link_monitor (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Synchronised link clock
  input  wire logic link_clk_s,
  // Results
  output logic      locked,
  output logic      frame_stb,
  output logic      rate48
);

  logic                                  prev_q;
  logic [input_select_pkg::cnt_w-1:0]    idle_q;
  logic [input_select_pkg::cnt_w-1:0]    per_q;
  logic [5:0]                            edge_q;
  logic                                  rise;

  assign rise = link_clk_s & ~prev_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= link_clk_s;
    end
  end

  // Loss is a long silence on the link, not a single missed edge
  always_ff @(posedge clk) begin
    if (rst) begin
      idle_q <= '0;
      locked <= 1'b0;
    end else if (rise) begin
      idle_q <= '0;
      locked <= 1'b1;
    end else if (idle_q ==
                 input_select_pkg::cnt_w'(input_select_pkg::lock_timeout_cyc))
    begin
      locked <= 1'b0;
    end else begin
      idle_q <= idle_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      edge_q    <= '0;
      per_q     <= '0;
      frame_stb <= 1'b0;
      rate48    <= 1'b0;
    end else begin
      frame_stb <= 1'b0;
      per_q     <= per_q + 1'b1;
      if (rise) begin
        edge_q <= edge_q + 1'b1;
        if (edge_q == 6'(input_select_pkg::frame_edges - 1)) begin
          frame_stb <= 1'b1;
          per_q     <= '0;
          rate48    <= (per_q <
                        input_select_pkg::cnt_w'(
                          input_select_pkg::mid_period_cyc));
        end
      end
    end
  end

endmodule

/* File: rtl/audio_input_select.sv */
// Purpose: Input source and sample rate selection with lock loss fallback
// Assumes: Avalon-MM slave, 10 MHz clk, link clock sampled as a pin
// Notes:   Outputs are registered; samples move on the sample strobe
//
// Notes on behaviour
// - Three input modes exist, analog 32000, analog 48000 or digital, set by the rate select.
// - Audio goes to the digital and analog outputs together in every mode.
// - The output rate always equals the rate of the selected input.
// - In digital mode the rate comes from the incoming digital stream.
// - Digital selected with no valid digital signal raises out of lock.
// - Out of lock while in line flashes the three digit display.
// - Out of lock with the analog policy switches processing to analog input.
// - Fallback samples at whichever fixed rate is nearer the last digital rate.
// - With no digital signal seen since power up, fallback uses 32000.
// - During fallback the digital output stays active at the analog rate.
// - Out of lock with the unlock policy mutes the audio outputs.
// - With the unlock policy the mute holds until lock is regained.
// - The rate select resets to analog at 48000.
// - The lock loss policy has two choices, revert to analog or mute.
// - Input attenuation is not applied to digital input audio.
`timescale 1ns/1ps
module audio_input_select (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  output logic             irq,
  // Digital link
  input  wire logic        link_clk,
  input  wire logic [23:0] digital_in,
  // Analog converter
  input  wire logic [23:0] analog_in,
  // Outputs
  output logic      [23:0] digital_out,
  output logic      [23:0] analog_out,
  output logic             sample_stb,
  output logic             rate48_out,
  output logic             display_blank
);

  // Control registers
  logic [1:0]  rate_sel_q;
  logic        policy_q;
  logic        inline_q;
  logic [5:0]  atten_q;
  logic [1:0]  irq_status_q;
  logic [1:0]  irq_mask_q;
  logic        ack_q;

  // Link synchroniser and monitor
  logic        link_s1_q;
  logic        link_s2_q;
  logic        locked;
  logic        frame_stb;
  logic        link_rate48;
  logic        locked_prev_q;
  logic        seen_q;
  logic        last48_q;

  // Derived state
  logic        digital_sel;
  logic        oolock;
  logic        use_digital;
  logic        mute;
  logic        cur48;
  logic [input_select_pkg::cnt_w-1:0] div_q;
  logic        fixed_stb;
  logic        stb;
  logic [input_select_pkg::cnt_w-1:0] flash_q;
  logic        flash_phase_q;
  logic [23:0] atten_sample;
  logic [23:0] sample_d;
  logic        lost_ev;
  logic        gain_ev;
  logic [31:0] rd_d;

  assign digital_sel = (rate_sel_q ==
                        input_select_pkg::digital_input_choice);
  assign oolock      = digital_sel & ~locked;
  assign use_digital = digital_sel & locked;
  assign mute        = oolock &
                       (policy_q == input_select_pkg::lock_loss_unlock);
  assign cur48 = use_digital ? link_rate48 :
                 digital_sel ? (seen_q & last48_q) :
                 (rate_sel_q == input_select_pkg::rate_48k_choice);
  assign lost_ev = locked_prev_q & ~locked & digital_sel;
  assign gain_ev = ~locked_prev_q & locked & digital_sel;

  // Synchroniser: only the second stage is read
  always_ff @(posedge clk) begin
    if (rst) begin
      link_s1_q <= 1'b0;
      link_s2_q <= 1'b0;
    end else begin
      link_s1_q <= link_clk;
      link_s2_q <= link_s1_q;
    end
  end

  link_monitor u_mon (
    .clk        (clk),
    .rst        (rst),
    .link_clk_s (link_s2_q),
    .locked     (locked),
    .frame_stb  (frame_stb),
    .rate48     (link_rate48)
  );

  // Last received rate persists while the link is gone
  always_ff @(posedge clk) begin
    if (rst) begin
      seen_q        <= 1'b0;
      last48_q      <= 1'b0;
      locked_prev_q <= 1'b0;
    end else begin
      locked_prev_q <= locked;
      if (frame_stb) begin
        seen_q   <= 1'b1;
        last48_q <= link_rate48;
      end
    end
  end

  // Fixed rate strobe for analog and fallback modes
  always_ff @(posedge clk) begin
    if (rst) begin
      div_q <= '0;
    end else if (fixed_stb) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // At or above the limit, so a switch to the shorter period never wraps
  assign fixed_stb = cur48 ?
    (div_q >= input_select_pkg::cnt_w'(input_select_pkg::div_48k_cyc - 1)) :
    (div_q >= input_select_pkg::cnt_w'(input_select_pkg::div_32k_cyc - 1));
  assign stb = use_digital ? frame_stb : fixed_stb;

  // Analog attenuation only; digital audio passes untouched
  assign atten_sample = 24'($signed(analog_in) >>> atten_q[4:0]);
  always_comb begin
    if (mute) begin
      sample_d = '0;
    end else if (use_digital) begin
      sample_d = digital_in;
    end else begin
      sample_d = atten_sample;
    end
  end

  // Both outputs carry the same sample at the same rate
  always_ff @(posedge clk) begin
    if (rst) begin
      digital_out <= '0;
      analog_out  <= '0;
      sample_stb  <= 1'b0;
      rate48_out  <= 1'b0;
    end else begin
      sample_stb <= stb;
      rate48_out <= cur48;
      if (stb) begin
        digital_out <= sample_d;
        analog_out  <= sample_d;
      end
    end
  end

  // Display flash
  always_ff @(posedge clk) begin
    if (rst) begin
      flash_q       <= '0;
      flash_phase_q <= 1'b0;
      display_blank <= 1'b0;
    end else begin
      if (flash_q ==
          input_select_pkg::cnt_w'(input_select_pkg::flash_cyc - 1)) begin
        flash_q       <= '0;
        flash_phase_q <= ~flash_phase_q;
      end else begin
        flash_q <= flash_q + 1'b1;
      end
      display_blank <= oolock & inline_q & flash_phase_q;
    end
  end

  // Control register writes
  always_ff @(posedge clk) begin
    if (rst) begin
      rate_sel_q <= input_select_pkg::rate_sel_rst;
      policy_q   <= input_select_pkg::policy_rst;
      inline_q   <= input_select_pkg::inline_rst;
      atten_q    <= input_select_pkg::atten_rst;
      irq_mask_q <= '0;
    end else if (write && !waitrequest) begin
      case (address)
        input_select_pkg::ctrl_off: begin
          // Reserved code 3 is ignored, keeping only three modes
          if (writedata[1:0] != 2'h3) begin
            rate_sel_q <= writedata[1:0];
          end
          policy_q <= writedata[input_select_pkg::ctrl_policy_bit];
          inline_q <= writedata[input_select_pkg::ctrl_inline_bit];
          atten_q  <= writedata[input_select_pkg::ctrl_atten_lsb +:
                                input_select_pkg::atten_w];
        end
        input_select_pkg::irq_mask_off: begin
          irq_mask_q <= writedata[1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Sticky events: a new event wins over a clearing write
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_status_q <= '0;
      irq           <= 1'b0;
    end else begin
      irq_status_q <= (irq_status_q &
        ~((write && !waitrequest &&
           address == input_select_pkg::irq_status_off) ?
          writedata[1:0] : 2'h0)) | {gain_ev, lost_ev};
      irq <= |(irq_status_q & irq_mask_q);
    end
  end

  always_comb begin
    rd_d = '0;
    case (address)
      input_select_pkg::ctrl_off: begin
        rd_d[1:0] = rate_sel_q;
        rd_d[input_select_pkg::ctrl_policy_bit] = policy_q;
        rd_d[input_select_pkg::ctrl_inline_bit] = inline_q;
        rd_d[input_select_pkg::ctrl_atten_lsb +:
             input_select_pkg::atten_w] = atten_q;
      end
      input_select_pkg::status_off: begin
        rd_d[input_select_pkg::st_lock_bit]    = locked;
        rd_d[input_select_pkg::st_oolock_bit]  = oolock;
        rd_d[input_select_pkg::st_digital_bit] = use_digital;
        rd_d[input_select_pkg::st_rate48_bit]  = cur48;
        rd_d[input_select_pkg::st_mute_bit]    = mute;
        rd_d[input_select_pkg::st_flash_bit]   = oolock & inline_q;
        rd_d[input_select_pkg::st_seen_bit]    = seen_q;
      end
      input_select_pkg::irq_status_off: rd_d[1:0] = irq_status_q;
      input_select_pkg::irq_mask_off:   rd_d[1:0] = irq_mask_q;
      default: rd_d = '0;
    endcase
  end

  // One wait cycle: request seen, then answered with waitrequest low
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_q       <= 1'b0;
      waitrequest <= 1'b1;
      readdata    <= '0;
    end else begin
      if ((read || write) && !ack_q) begin
        ack_q       <= 1'b1;
        waitrequest <= 1'b0;
        // Writes leave the last read answer standing
        if (read) begin
          readdata <= rd_d;
        end
      end else begin
        ack_q       <= 1'b0;
        waitrequest <= 1'b1;
      end
    end
  end

endmodule

/* File: test/audio_input_select_sva.sv */
// Purpose: Port checks for the input select block
// Assumes: Control and mask are mirrored from accepted bus writes
// Notes:   A quiet count skips the cycles right after any write
`timescale 1ns/1ps
module audio_input_select_sva (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Bus
  input wire logic [3:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        irq,
  // Outputs
  input wire logic [23:0] digital_out,
  input wire logic [23:0] analog_out,
  input wire logic        sample_stb,
  input wire logic        rate48_out,
  input wire logic        display_blank
);
  logic [13:0] ctrl_q;
  logic [1:0]  mask_q;
  logic [9:0]  quiet_q;
  logic [9:0]  gap_q;
  logic        acc;
  logic        fixed;
  assign acc   = write && !waitrequest;
  assign fixed = !ctrl_q[1] && quiet_q > 10'h2bc;
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= 14'h0005;
      mask_q <= 2'h0;
    end else if (acc && address == input_select_pkg::ctrl_off) begin
      // Rate code 3 is refused, the old rate stays
      ctrl_q <= {writedata[13:2],
        (writedata[1:0] == 2'h3) ? ctrl_q[1:0] : writedata[1:0]};
    end else if (acc && address == input_select_pkg::irq_mask_off) begin
      mask_q <= writedata[1:0];
    end
  end
  always_ff @(posedge clk) begin
    if (rst || acc) quiet_q <= 10'h000;
    else if (quiet_q != 10'h3ff) quiet_q <= quiet_q + 10'h001;
  end
  always_ff @(posedge clk) begin
    if (rst || sample_stb) gap_q <= 10'h001;
    else if (gap_q != 10'h3ff) gap_q <= gap_q + 10'h001;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_wait_one: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low longer than one cycle");
  chk_wait_answer: assert property ((read || write) && waitrequest
    |=> !waitrequest) else $error("request not answered next cycle");
  chk_read_stands: assert property ($changed(readdata)
    |-> !waitrequest && read) else $error("readdata moved outside a read");
  chk_outs_equal: assert property (digital_out == analog_out)
    else $error("digital and analog outputs differ");
  chk_stb_pulse: assert property (sample_stb |=> !sample_stb)
    else $error("sample strobe longer than one cycle");
  chk_stb_spacing: assert property (sample_stb && fixed
    |-> gap_q == (ctrl_q[0] ? 10'h0d0 : 10'h138))
    else $error("fixed rate strobe spacing wrong");
  chk_rate_fixed: assert property (sample_stb && fixed
    |-> rate48_out == ctrl_q[0]) else $error("rate flag wrong");
  chk_blank_inline: assert property (quiet_q > 10'h002 && !ctrl_q[3]
    |-> !display_blank) else $error("display flashes while bypassed");
  chk_irq_masked: assert property (quiet_q > 10'h002 && mask_q == 2'h0
    |-> !irq) else $error("irq high with all events masked");
  cover property (sample_stb && rate48_out);
  cover property (irq);
  cover property (read && !waitrequest);
endmodule

bind audio_input_select audio_input_select_sva chk_u (
  .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
  .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
  .irq(irq), .digital_out(digital_out), .analog_out(analog_out),
  .sample_stb(sample_stb), .rate48_out(rate48_out),
  .display_blank(display_blank)
);

/* File: test/link_source.sv */
// Purpose: Digital link source driving link clock and samples
// Assumes: Clock stands still low while disabled
// Notes:   Samples move mid frame, away from the frame edge
`timescale 1ns/1ps
module link_source (
  // Control
  input wire logic en,
  input wire logic fast,
  // Link pins
  output logic        link_clk,
  output logic [23:0] sample
);
  int edges;
  initial begin
    link_clk = 1'b0;
    sample   = 24'h123456;
    edges    = 0;
    #37;
    forever begin
      if (en) begin
        #(fast ? 100 : 400);
        link_clk = 1'b1;
        edges++;
        if (edges % 64 == 32) sample = sample + 24'h010203;
        #(fast ? 100 : 400);
        link_clk = 1'b0;
      end else begin
        // A released line must not keep showing the last sample
        #100;
        sample = ~sample;
      end
    end
  end
endmodule

/* File: test/audio_input_select_bench.sv */
// Purpose: Self-checking bench for the input select block
// Assumes: Link source model drives the link pins
// Notes:   Flash period is too long to watch; the checker only checks for no blanking while bypassed
`timescale 1ns/1ps
module audio_input_select_bench;
  logic        clk;
  logic        rst;
  logic [3:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        irq;
  logic        link_clk;
  logic [23:0] digital_in;
  logic [23:0] analog_in;
  logic [23:0] digital_out;
  logic [23:0] analog_out;
  logic        sample_stb;
  logic        rate48_out;
  logic        display_blank;
  logic        link_en;
  logic        link_fast;
  logic [31:0] q;
  int          g;
  int          err_count;
  int          comparisons;
  localparam logic [23:0] att2 = 24'he00040;
  audio_input_select dut_u (.clk(clk), .rst(rst), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
    .link_clk(link_clk), .digital_in(digital_in), .analog_in(analog_in),
    .digital_out(digital_out), .analog_out(analog_out),
    .sample_stb(sample_stb), .rate48_out(rate48_out),
    .display_blank(display_blank));
  link_source src_u (.en(link_en), .fast(link_fast),
    .link_clk(link_clk), .sample(digital_in));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    address   <= a;
    writedata <= d;
    write     <= w;
    read      <= !w;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    write <= 1'b0;
    read  <= 1'b0;
  endtask
  task two_stb;
    for (int k = 0; k < 2; k++) begin
      g = 0;
      do begin
        @(posedge clk);
        g++;
      end while (sample_stb !== 1'b1);
    end
  endtask
  task t_reset;
    bus(1'b0, input_select_pkg::ctrl_off, 32'h0);
    check(q, 32'h00000005);
    bus(1'b0, 4'h2, 32'h0);
    check(q, 32'h0);
    two_stb;
    check(rate48_out, 1'b1);
  endtask
  task t_fixed;
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, input_select_pkg::ctrl_off, 32'h4 | 32'(i));
      two_stb;
      check(g, i ? 208 : 312);
      check(rate48_out, i[0]);
      check(analog_out, analog_in);
      check(digital_out, analog_in);
    end
    bus(1'b1, input_select_pkg::ctrl_off, 32'h7);
    bus(1'b0, input_select_pkg::ctrl_off, 32'h0);
    check(q[1:0], 2'h1);
  endtask
  task t_nolink;
    bus(1'b1, input_select_pkg::ctrl_off, 32'h20e);
    bus(1'b1, input_select_pkg::irq_mask_off, 32'h3);
    repeat (1100) @(posedge clk);
    bus(1'b0, input_select_pkg::status_off, 32'h0);
    check(q[1], 1'b1);
    check(q[5], 1'b1);
    check(q[6], 1'b0);
    two_stb;
    check(g, 312);
    check(analog_out, att2);
    check(digital_out, att2);
  endtask
  task t_digital;
    link_en <= 1'b1;
    repeat (1200) @(posedge clk);
    bus(1'b0, input_select_pkg::status_off, 32'h0);
    check({q[5], q[1], q[0]}, 3'h1);
    bus(1'b0, input_select_pkg::irq_status_off, 32'h0);
    check(q[1], 1'b1);
    check(irq, 1'b1);
    bus(1'b1, input_select_pkg::irq_status_off, 32'h3);
    repeat (3) @(posedge clk);
    check(irq, 1'b0);
    two_stb;
    check(g, 512);
    check(rate48_out, 1'b0);
    check(digital_out, digital_in);
  endtask
  task t_fast;
    link_fast <= 1'b1;
    repeat (1200) @(posedge clk);
    two_stb;
    check(g, 128);
    check(rate48_out, 1'b1);
    link_en <= 1'b0;
    repeat (1200) @(posedge clk);
    bus(1'b0, input_select_pkg::irq_status_off, 32'h0);
    check(q[0], 1'b1);
    two_stb;
    check(g, 208);
    check(analog_out, att2);
    check(digital_out, att2);
  endtask
  task t_mute;
    bus(1'b1, input_select_pkg::ctrl_off, 32'h20a);
    two_stb;
    check(analog_out, 24'h0);
    two_stb;
    check(digital_out, 24'h0);
    link_fast <= 1'b0;
    link_en   <= 1'b1;
    repeat (1200) @(posedge clk);
    two_stb;
    check(analog_out, digital_in);
  endtask
  task test_done;
    if (err_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    rst         = 1'b1;
    address     = 4'h0;
    read        = 1'b0;
    write       = 1'b0;
    writedata   = 32'h0;
    analog_in   = 24'h800100;
    link_en     = 1'b0;
    link_fast   = 1'b0;
    err_count   = 0;
    comparisons = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_fixed;
    t_nolink;
    t_digital;
    t_fast;
    t_mute;
    test_done;
  end
  // Whole run needs well under half this span
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    test_done;
  end
endmodule
